/* File: rtl/sbc_bank_check.sv */
`timescale 1ns/1ps
module sbc_bank_check #(
  parameter int BANKS = sbc_pkg::BANKS,
  parameter int RP_CYC = sbc_pkg::T_RP_CYC,
  parameter int RCD_CYC = sbc_pkg::T_RCD_CYC,
  parameter int WR_CYC = sbc_pkg::T_WR_CYC,
  parameter int RFC_CYC = sbc_pkg::T_RFC_CYC,
  parameter int BURST_CYC = sbc_pkg::BURST_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command pins from the memory controller
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sbc_pkg::BA_W-1:0] bank_addr,
  input wire logic auto_pre,
  // Per-bank state and verdicts
  output logic [BANKS-1:0] bank_busy,
  output logic [BANKS-1:0] bank_open,
  output logic [BANKS-1:0] bank_refreshing,
  output logic cmd_noop,
  output logic cmd_legal,
  output logic cmd_illegal
);

  localparam int PW = 4 + sbc_pkg::BA_W + 1;

  logic [PW-1:0] pins_s;
  logic [sbc_pkg::CNT_W-1:0] cnt_q [BANKS];
  logic [sbc_pkg::CNT_W-1:0] cnt_d [BANKS];
  sbc_pkg::sbc_state_e st_q [BANKS];
  sbc_pkg::sbc_state_e st_d [BANKS];
  logic [BANKS-1:0] ok_d;
  logic [BANKS-1:0] noop_d;
  logic [BANKS-1:0] tgt;
  logic ref_q;
  logic [sbc_pkg::CNT_W-1:0] ref_cnt_q;
  logic noop_q;
  logic legal_q;
  logic illegal_q;

  sbc_cmd_sync #(.WIDTH(PW)) u_sync (
    .clk(clk),
    .reset(reset),
    .pin_in({cs_n, ras_n, cas_n, we_n, bank_addr, auto_pre}),
    .pin_out(pins_s)
  );

  function automatic sbc_pkg::sbc_cmd_e decode(input logic [3:0] p);
    if (p[3])
      return sbc_pkg::SBC_CMD_DESEL;
    unique case (p[2:0])
      3'h7: return sbc_pkg::SBC_CMD_NOP;
      3'h5: return sbc_pkg::SBC_CMD_READ;
      3'h4: return sbc_pkg::SBC_CMD_WRITE;
      3'h3: return sbc_pkg::SBC_CMD_ACT;
      3'h2: return sbc_pkg::SBC_CMD_PRE;
      3'h1: return sbc_pkg::SBC_CMD_REF;
      default: return sbc_pkg::SBC_CMD_MRS;
    endcase
  endfunction

  function automatic logic [sbc_pkg::CNT_W-1:0] cyc(input int n);
    return sbc_pkg::CNT_W'(n > 0 ? n - 1 : 0);
  endfunction

  wire sbc_pkg::sbc_cmd_e cmd = decode(pins_s[PW-1:PW-4]);
  wire [sbc_pkg::BA_W-1:0] ba = pins_s[2:1];
  wire ap = pins_s[0];
  wire idle_cmd = (cmd == sbc_pkg::SBC_CMD_DESEL) || (cmd == sbc_pkg::SBC_CMD_NOP);
  // A10 high with precharge selects all banks.
  wire pre_all = (cmd == sbc_pkg::SBC_CMD_PRE) && ap;
  wire all_idle = ~|bank_busy & ~|bank_open;

  // Each bank judges the command only when it is addressed (or when all are).
  always_comb
  begin
    for (int b = 0; b < BANKS; b++)
    begin
      tgt[b] = (ba == b[sbc_pkg::BA_W-1:0]) || pre_all;
      st_d[b] = st_q[b];
      cnt_d[b] = (cnt_q[b] != '0) ? cnt_q[b] - 1'b1 : cnt_q[b];
      ok_d[b] = 1'b1;
      noop_d[b] = 1'b0;
      unique case (st_q[b])
        sbc_pkg::SBC_ST_IDLE:
        begin
          if (tgt[b] && cmd == sbc_pkg::SBC_CMD_ACT && !ref_q)
          begin
            st_d[b] = sbc_pkg::SBC_ST_ROWACT;
            cnt_d[b] = cyc(RCD_CYC);
          end
        end
        sbc_pkg::SBC_ST_ACTIVE, sbc_pkg::SBC_ST_READ, sbc_pkg::SBC_ST_WRITE:
        begin
          if (cnt_q[b] == '0 && st_q[b] == sbc_pkg::SBC_ST_WRITE)
          begin
            st_d[b] = sbc_pkg::SBC_ST_WREC;
            cnt_d[b] = cyc(WR_CYC);
          end
          else if (cnt_q[b] == '0)
            st_d[b] = sbc_pkg::SBC_ST_ACTIVE;
          if (tgt[b] && cmd == sbc_pkg::SBC_CMD_PRE)
          begin
            st_d[b] = sbc_pkg::SBC_ST_PRECHG;
            cnt_d[b] = cyc(RP_CYC);
          end
          else if (tgt[b] && cmd == sbc_pkg::SBC_CMD_READ)
          begin
            st_d[b] = ap ? sbc_pkg::SBC_ST_RDA : sbc_pkg::SBC_ST_READ;
            cnt_d[b] = cyc(BURST_CYC);
          end
          else if (tgt[b] && cmd == sbc_pkg::SBC_CMD_WRITE)
          begin
            st_d[b] = ap ? sbc_pkg::SBC_ST_WRA : sbc_pkg::SBC_ST_WRITE;
            cnt_d[b] = cyc(BURST_CYC);
          end
          else if (tgt[b] && cmd == sbc_pkg::SBC_CMD_ACT)
            ok_d[b] = 1'b0;
        end
        sbc_pkg::SBC_ST_RDA, sbc_pkg::SBC_ST_WRA:
        begin
          noop_d[b] = tgt[b] && idle_cmd;
          ok_d[b] = !tgt[b] || idle_cmd;
          if (cnt_q[b] == '0)
          begin
            // The burst ran to its end; a read goes to precharge, a write to write recovery first.
            st_d[b] = (st_q[b] == sbc_pkg::SBC_ST_RDA) ? sbc_pkg::SBC_ST_PRECHG
                                                       : sbc_pkg::SBC_ST_WRECA;
            cnt_d[b] = (st_q[b] == sbc_pkg::SBC_ST_RDA) ? cyc(RP_CYC) : cyc(WR_CYC);
          end
        end
        sbc_pkg::SBC_ST_PRECHG:
        begin
          noop_d[b] = tgt[b] && (idle_cmd || cmd == sbc_pkg::SBC_CMD_PRE);
          ok_d[b] = !tgt[b] || noop_d[b];
          if (cnt_q[b] == '0)
            st_d[b] = sbc_pkg::SBC_ST_IDLE;
        end
        sbc_pkg::SBC_ST_ROWACT:
        begin
          noop_d[b] = tgt[b] && idle_cmd;
          ok_d[b] = !tgt[b] || idle_cmd;
          if (cnt_q[b] == '0)
            st_d[b] = sbc_pkg::SBC_ST_ACTIVE;
        end
        sbc_pkg::SBC_ST_WREC:
        begin
          noop_d[b] = tgt[b] && idle_cmd;
          if (cnt_q[b] == '0)
            st_d[b] = sbc_pkg::SBC_ST_ACTIVE;
          if (tgt[b] && cmd == sbc_pkg::SBC_CMD_WRITE)
          begin
            st_d[b] = ap ? sbc_pkg::SBC_ST_WRA : sbc_pkg::SBC_ST_WRITE;
            cnt_d[b] = cyc(BURST_CYC);
          end
          else
            ok_d[b] = !tgt[b] || idle_cmd;
        end
        sbc_pkg::SBC_ST_WRECA:
        begin
          noop_d[b] = tgt[b] && idle_cmd;
          ok_d[b] = !tgt[b] || idle_cmd;
          if (cnt_q[b] == '0)
          begin
            st_d[b] = sbc_pkg::SBC_ST_PRECHG;
            cnt_d[b] = cyc(RP_CYC);
          end
        end
      endcase
    end
  end

  // Refresh and mode setting need every bank idle; during refresh only no-ops pass.
  wire ref_start = cmd == sbc_pkg::SBC_CMD_REF && all_idle && !ref_q;
  wire glob_bad = ref_q ? !idle_cmd
    : ((cmd == sbc_pkg::SBC_CMD_REF || cmd == sbc_pkg::SBC_CMD_MRS) && !all_idle);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int b = 0; b < BANKS; b++)
      begin
        st_q[b] <= sbc_pkg::SBC_ST_IDLE;
        cnt_q[b] <= '0;
      end
      ref_q <= 1'b0;
      ref_cnt_q <= '0;
      noop_q <= 1'b0;
      legal_q <= 1'b0;
      illegal_q <= 1'b0;
    end
    else
    begin
      for (int b = 0; b < BANKS; b++)
      begin
        st_q[b] <= ref_q ? st_q[b] : st_d[b];
        cnt_q[b] <= ref_q ? cnt_q[b] : cnt_d[b];
      end
      if (ref_start)
      begin
        ref_q <= 1'b1;
        ref_cnt_q <= cyc(RFC_CYC);
      end
      else if (ref_q && ref_cnt_q == '0)
        ref_q <= 1'b0;
      else if (ref_q)
        ref_cnt_q <= ref_cnt_q - 1'b1;
      noop_q <= ref_q ? idle_cmd : |noop_d;
      illegal_q <= glob_bad || (!ref_q && !(&ok_d));
      legal_q <= !glob_bad && (ref_q || (&ok_d));
    end
  end

  always_comb
  begin
    for (int b = 0; b < BANKS; b++)
    begin
      bank_busy[b] = !(st_q[b] inside {sbc_pkg::SBC_ST_IDLE, sbc_pkg::SBC_ST_ACTIVE});
      bank_open[b] = st_q[b] == sbc_pkg::SBC_ST_ACTIVE;
    end
    bank_refreshing = {BANKS{ref_q}};
  end

  assign cmd_noop = noop_q;
  assign cmd_legal = legal_q;
  assign cmd_illegal = illegal_q;

endmodule

/* File: include/sbc_pkg.sv */
// What this block does
// - Read with auto precharge: deselect and no-op are no-ops; burst runs to end.
// - Write with auto precharge: deselect and no-op are no-ops; burst completes.
// - Precharging: deselect, no-op, precharge and precharge-all are no-ops; idle after tRP.
// - Activating: deselect and no-op are no-ops; bank active after tRCD.
// - Write recovering: no-ops until tWR then active; new write accepted.
// - Write recovering with auto precharge: no-ops until tWR; other commands illegal.
// - Refresh: no-ops, idle after tRFC; any other command meanwhile is illegal.
package sbc_pkg;

  localparam int CLK_PERIOD_PS = 10000;
  localparam int T_RP_PS = 15000;
  localparam int T_RCD_PS = 15000;
  localparam int T_WR_PS = 15000;
  localparam int T_RFC_PS = 105000;
  localparam int T_RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_RCD_CYC = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_WR_CYC = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BURST_LEN = 4;
  localparam int BURST_CYC = BURST_LEN / 2;
  localparam int CNT_W = 8;
  localparam int BANKS = 4;
  localparam int BA_W = 2;

  typedef enum logic [3:0]
  {
    SBC_CMD_DESEL = 4'h0,
    SBC_CMD_NOP = 4'h1,
    SBC_CMD_READ = 4'h2,
    SBC_CMD_WRITE = 4'h3,
    SBC_CMD_ACT = 4'h4,
    SBC_CMD_PRE = 4'h5,
    SBC_CMD_REF = 4'h6,
    SBC_CMD_MRS = 4'h7
  } sbc_cmd_e;

  typedef enum logic [9:0]
  {
    SBC_ST_IDLE = 10'h001,
    SBC_ST_ACTIVE = 10'h002,
    SBC_ST_READ = 10'h004,
    SBC_ST_WRITE = 10'h008,
    SBC_ST_RDA = 10'h010,
    SBC_ST_WRA = 10'h020,
    SBC_ST_PRECHG = 10'h040,
    SBC_ST_ROWACT = 10'h080,
    SBC_ST_WREC = 10'h100,
    SBC_ST_WRECA = 10'h200
  } sbc_state_e;

endpackage

/* File: rtl/sbc_cmd_sync.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages two and three agree.
module sbc_cmd_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins in, settled value out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      out_q <= '1;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (agree & s3_q) | (~agree & out_q);
    end
  end

  assign pin_out = out_q;

endmodule

/* File: verification/sbc_bank_check_props.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Verdict and bank state checks.
// ----------------------------------------
module sbc_bank_check_props #(
  parameter int BANKS = 4,
  parameter int RFC_CYC = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched signals
  input wire logic cs_n,
  input wire logic [BANKS-1:0] bank_busy,
  input wire logic [BANKS-1:0] bank_open,
  input wire logic [BANKS-1:0] bank_refreshing,
  input wire logic cmd_noop,
  input wire logic cmd_legal,
  input wire logic cmd_illegal
);
  localparam int REF_LO = RFC_CYC;
  localparam int REF_HI = RFC_CYC;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Every busy state lasts two cycles at least, so no exit may follow a one-cycle stay.
  sequence s_busy_two;
    $past(bank_busy[0]) && $past(bank_busy[0], 2);
  endsequence
  property p_one_verdict; $onehot0({cmd_legal, cmd_illegal}); endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("two verdicts");
  // A no-op is an accepted command, so it comes with the legal verdict, except a precharge-all that another busy bank rejects.
  property p_noop_legal; cmd_noop |-> cmd_legal; endproperty
  a_noop_legal: assert property (p_noop_legal) else $error("no-op not legal");
  property p_desel_quiet; cs_n [*6] |=> !cmd_illegal; endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("deselect illegal");
  property p_open_busy; (bank_open & bank_busy) == '0; endproperty
  a_open_busy: assert property (p_open_busy) else $error("open and busy");
  property p_rowact; $rose(bank_open[0]) |-> s_busy_two; endproperty
  a_rowact: assert property (p_rowact) else $error("opened too early");
  property p_pre_idle; $fell(bank_busy[0]) && !bank_open[0] |-> s_busy_two; endproperty
  a_pre_idle: assert property (p_pre_idle) else $error("idle too early");
  property p_ref_quiet; bank_refreshing[0] |-> (bank_busy | bank_open) == '0; endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("bank moved in refresh");
  property p_ref_all; bank_refreshing == {BANKS{bank_refreshing[0]}}; endproperty
  a_ref_all: assert property (p_ref_all) else $error("refresh flags differ");
  property p_ref_end; $rose(bank_refreshing[0]) |-> ##[REF_LO:REF_HI] !bank_refreshing[0];
  endproperty
  a_ref_end: assert property (p_ref_end) else $error("refresh length wrong");
endmodule
bind sbc_bank_check sbc_bank_check_props #(.BANKS(BANKS), .RFC_CYC(RFC_CYC)) u_props (
  .clk(clk), .reset(reset), .cs_n(cs_n), .bank_busy(bank_busy), .bank_open(bank_open),
  .bank_refreshing(bank_refreshing), .cmd_noop(cmd_noop), .cmd_legal(cmd_legal),
  .cmd_illegal(cmd_illegal));

/* File: verification/sbc_ctrl_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Memory controller driving the command pins.
// ----------------------------------------
module sbc_ctrl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [sbc_pkg::BA_W-1:0] bank_addr,
  output logic auto_pre
);
  // Deselect drives the other pins low, so a device that ignores chip select misreads it.
  localparam logic [3:0] PINS [8] = '{4'h8, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = PINS[0];
    bank_addr = '0;
    auto_pre = 1'b0;
  end
  task automatic put(input sbc_pkg::sbc_cmd_e c, input logic [1:0] b, input logic a);
    @(posedge clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = PINS[c];
    bank_addr = b;
    auto_pre = a;
  endtask
  // Held over two edges so the synchroniser stages agree; illegal ones only on request.
  task automatic issue(input sbc_pkg::sbc_cmd_e c, input logic [1:0] b, input logic a);
    put(c, b, a);
    @(posedge clk);
    put(sbc_pkg::SBC_CMD_DESEL, b, 1'b0);
  endtask
endmodule

/* File: verification/sbc_bank_check_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Harness.
// ----------------------------------------
module sbc_bank_check_tb;
  // Long timers leave each probe a clear window inside one busy state.
  localparam int T = 28;
  logic clk;
  logic reset;
  logic cs_n, ras_n, cas_n, we_n, auto_pre, cmd_noop, cmd_legal, cmd_illegal;
  logic [1:0] bank_addr;
  logic [3:0] bank_busy, bank_open, bank_refreshing;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic own_noop = 1'b0;
  sbc_bank_check #(.RP_CYC(T), .RCD_CYC(T), .WR_CYC(T), .RFC_CYC(T), .BURST_CYC(T))
    u_sbc_bank_check (.clk(clk), .reset(reset), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_addr(bank_addr), .auto_pre(auto_pre), .bank_busy(bank_busy),
    .bank_open(bank_open), .bank_refreshing(bank_refreshing), .cmd_noop(cmd_noop),
    .cmd_legal(cmd_legal), .cmd_illegal(cmd_illegal));
  sbc_ctrl_model u_sbc_ctrl_model (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_addr(bank_addr), .auto_pre(auto_pre));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks and scenarios.
  // ----------------------------------------
  task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdicts lag the pins by five cycles, so the window skips older commands.
  // Its third cycle carries the first verdict on this command.
  task probe(input sbc_pkg::sbc_cmd_e c, input logic [1:0] b, input logic exp);
    logic seen;
    logic own_legal;
    seen = 1'b0;
    own_legal = 1'b0;
    repeat (3) @(posedge clk);
    u_sbc_ctrl_model.issue(c, b, 1'b0);
    for (int i = 1; i <= 8; i++)
    begin
      @(posedge clk);
      #2;
      seen = seen | cmd_illegal;
      if (i == 3)
      begin
        own_noop = cmd_noop;
        own_legal = cmd_legal;
      end
    end
    check("cmd_illegal", 4'(seen), 4'(exp));
    check("cmd_legal", 4'(own_legal), 4'(!exp));
  endtask
  task settle(input logic [3:0] open_exp);
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    #2;
    while (n < 200 && (bank_busy !== 4'h0 || bank_refreshing !== 4'h0))
    begin
      @(posedge clk);
      #2;
      n++;
    end
    check("bank_open", bank_open, open_exp);
    check("bank_busy", bank_busy | bank_refreshing, 4'h0);
  endtask
  task send(input sbc_pkg::sbc_cmd_e c, input logic [1:0] b, input logic a);
    u_sbc_ctrl_model.issue(c, b, a);
  endtask
  task t_row_activate;
    send(sbc_pkg::SBC_CMD_ACT, 2'h0, 1'b0);
    probe(sbc_pkg::SBC_CMD_NOP, 2'h0, 1'b0);
    check("cmd_noop", 4'(own_noop), 4'h1);
    probe(sbc_pkg::SBC_CMD_ACT, 2'h0, 1'b1);
    check("cmd_noop", 4'(own_noop), 4'h0);
    settle(4'h1);
  endtask
  task t_read_auto;
    send(sbc_pkg::SBC_CMD_READ, 2'h0, 1'b1);
    probe(sbc_pkg::SBC_CMD_DESEL, 2'h0, 1'b0);
    check("cmd_noop", 4'(own_noop), 4'h1);
    probe(sbc_pkg::SBC_CMD_WRITE, 2'h0, 1'b1);
    probe(sbc_pkg::SBC_CMD_PRE, 2'h0, 1'b0);
    check("cmd_noop", 4'(own_noop), 4'h1);
    settle(4'h0);
  endtask
  task t_write_auto;
    send(sbc_pkg::SBC_CMD_ACT, 2'h0, 1'b0);
    settle(4'h1);
    send(sbc_pkg::SBC_CMD_WRITE, 2'h0, 1'b1);
    probe(sbc_pkg::SBC_CMD_NOP, 2'h0, 1'b0);
    check("cmd_noop", 4'(own_noop), 4'h1);
    probe(sbc_pkg::SBC_CMD_REF, 2'h0, 1'b1);
    probe(sbc_pkg::SBC_CMD_MRS, 2'h0, 1'b1);
    probe(sbc_pkg::SBC_CMD_ACT, 2'h0, 1'b1);
    settle(4'h0);
  endtask
  task t_write_recover;
    send(sbc_pkg::SBC_CMD_ACT, 2'h0, 1'b0);
    settle(4'h1);
    send(sbc_pkg::SBC_CMD_WRITE, 2'h0, 1'b0);
    repeat (3) probe(sbc_pkg::SBC_CMD_NOP, 2'h0, 1'b0);
    check("cmd_noop", 4'(own_noop), 4'h1);
    send(sbc_pkg::SBC_CMD_WRITE, 2'h0, 1'b0);
    repeat (20) @(posedge clk);
    #2;
    check("bank_busy", bank_busy, 4'h1);
    settle(4'h1);
  endtask
  task t_refresh;
    send(sbc_pkg::SBC_CMD_PRE, 2'h0, 1'b0);
    settle(4'h0);
    send(sbc_pkg::SBC_CMD_REF, 2'h0, 1'b0);
    probe(sbc_pkg::SBC_CMD_NOP, 2'h1, 1'b0);
    check("cmd_noop", 4'(own_noop), 4'h1);
    check("bank_refreshing", bank_refreshing, 4'hf);
    probe(sbc_pkg::SBC_CMD_ACT, 2'h1, 1'b1);
    settle(4'h0);
    send(sbc_pkg::SBC_CMD_ACT, 2'h1, 1'b0);
    settle(4'h2);
  endtask
  task give_verdict;
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    reset = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    t_row_activate();
    t_read_auto();
    t_write_auto();
    t_write_recover();
    t_refresh();
    give_verdict();
  end
endmodule
